// [common/tlc_pkg.sv]
// Constants and types shared by the line-coding host controller.
// Assumes a 250 MHz system clock and a separate link word clock.
package tlc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int SPI_MAX_KHZ = 13500;
  localparam int SPI_HALF = (CLK_KHZ + 2 * SPI_MAX_KHZ - 1) / (2 * SPI_MAX_KHZ);
  localparam int SPI_CNT_W = 5;
  // ----------------------------------------
  // Packet layout
  // ----------------------------------------
  localparam int PKT_DATA_LEN = 188;
  localparam int PKT_EXTRA_LEN = 16;
  localparam int PKT_LONG_LEN = PKT_DATA_LEN + PKT_EXTRA_LEN;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  // ----------------------------------------
  // Serial link codes
  // ----------------------------------------
  localparam logic [9:0] COMMA_NEG = 10'h0fa;
  localparam logic [9:0] COMMA_POS = 10'h305;
  localparam logic [1:0] MIN_SYNC = 2'h2;
  localparam logic [3:0] ALIGN_LAST = 4'h9;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] IDX_RST = 8'h00;
  localparam logic [9:0] WORD_RST = 10'h000;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    FMT_188 = 2'b00,
    FMT_204_DUMMY = 2'b01,
    FMT_204_VALID = 2'b11
  } tlc_fmt_t;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_LOW = 2'b01,
    SPI_HIGH = 2'b11
  } tlc_spi_state_t;
endpackage

// [hdl/tlc_host.sv]
// Host controller feeding a transport stream transcoder over the parallel byte
// interface and the 8B/10B serial interface, and receiving the serial return.
// Assumes link_clk is the serializer word clock and rx words arrive on it.
`timescale 1ns/10ps
module tlc_host
  import tlc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic [1:0] pkt_fmt,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  output logic src_ready,
  output logic spi_clk,
  output logic [7:0] spi_data,
  output logic packet_start_flag,
  output logic byte_valid_flag,
  input wire logic asi_in_valid,
  input wire logic asi_in_start,
  input wire logic [7:0] asi_in_data,
  output logic asi_in_ready,
  output logic [9:0] asi_tx_word,
  input wire logic [9:0] asi_rx_word,
  output logic asi_out_valid,
  output logic [7:0] asi_out_data,
  output logic asi_locked
);
  // ----------------------------------------
  // 8B/10B coding functions
  // ----------------------------------------
  function automatic logic [10:0] enc(input logic [7:0] b, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic rd6;
    logic alt;
    c6 = 6'h00;
    c4 = 4'h0;
    rd6 = rd;
    alt = 1'b0;
    if (k) begin
      enc = rd ? {1'b0, COMMA_POS} : {1'b1, COMMA_NEG};
    end else begin
      case (b[4:0])
        5'd0: c6 = 6'b100111;
        5'd1: c6 = 6'b011101;
        5'd2: c6 = 6'b101101;
        5'd3: c6 = 6'b110001;
        5'd4: c6 = 6'b110101;
        5'd5: c6 = 6'b101001;
        5'd6: c6 = 6'b011001;
        5'd7: c6 = 6'b111000;
        5'd8: c6 = 6'b111001;
        5'd9: c6 = 6'b100101;
        5'd10: c6 = 6'b010101;
        5'd11: c6 = 6'b110100;
        5'd12: c6 = 6'b001101;
        5'd13: c6 = 6'b101100;
        5'd14: c6 = 6'b011100;
        5'd15: c6 = 6'b010111;
        5'd16: c6 = 6'b011011;
        5'd17: c6 = 6'b100011;
        5'd18: c6 = 6'b010011;
        5'd19: c6 = 6'b110010;
        5'd20: c6 = 6'b001011;
        5'd21: c6 = 6'b101010;
        5'd22: c6 = 6'b011010;
        5'd23: c6 = 6'b111010;
        5'd24: c6 = 6'b110011;
        5'd25: c6 = 6'b100110;
        5'd26: c6 = 6'b010110;
        5'd27: c6 = 6'b110110;
        5'd28: c6 = 6'b001110;
        5'd29: c6 = 6'b101110;
        5'd30: c6 = 6'b011110;
        default: c6 = 6'b101011;
      endcase
      if (rd && ($countones(c6) != 3 || b[4:0] == 5'd7)) begin
        c6 = ~c6;
      end
      if ($countones(c6) != 3) begin
        rd6 = ~rd;
      end
      alt = (!rd6 && (b[4:0] == 5'd17 || b[4:0] == 5'd18 || b[4:0] == 5'd20)) ||
            (rd6 && (b[4:0] == 5'd11 || b[4:0] == 5'd13 || b[4:0] == 5'd14));
      case (b[7:5])
        3'd0: c4 = 4'b1011;
        3'd1: c4 = 4'b1001;
        3'd2: c4 = 4'b0101;
        3'd3: c4 = 4'b1100;
        3'd4: c4 = 4'b1101;
        3'd5: c4 = 4'b1010;
        3'd6: c4 = 4'b0110;
        default: c4 = alt ? 4'b0111 : 4'b1110;
      endcase
      if (rd6 && ($countones(c4) != 2 || b[7:5] == 3'd3)) begin
        c4 = ~c4;
      end
      enc = {(($countones(c4) != 2) ? ~rd6 : rd6), c6, c4};
    end
  endfunction

  function automatic logic [8:0] dec(input logic [9:0] w);
    logic [10:0] e;
    dec = 9'h000;
    e = 11'h000;
    for (int i = 0; i < 256; i++) begin
      for (int r = 0; r < 2; r++) begin
        e = enc(8'(i), 1'b0, r[0]);
        if (e[9:0] == w) begin
          dec = {1'b1, 8'(i)};
        end
      end
    end
  endfunction

  // ----------------------------------------
  // Parallel byte interface
  // ----------------------------------------
  tlc_spi_state_t spi_state_reg, spi_state_next;
  tlc_fmt_t fmt_reg, fmt_next;
  logic [SPI_CNT_W-1:0] div_cnt_reg, div_cnt_next;
  logic [7:0] idx_reg, idx_next;
  logic spi_clk_reg, spi_clk_next;
  logic [7:0] spi_data_reg, spi_data_next;
  logic start_reg, start_next;
  logic valid_reg, valid_next;
  tlc_fmt_t cur_fmt;
  logic half_done, extra_slot, dummy_slot, avail, load;
  logic [7:0] cur_idx;

  always_comb begin
    spi_state_next = spi_state_reg;
    fmt_next = fmt_reg;
    div_cnt_next = div_cnt_reg;
    idx_next = idx_reg;
    spi_clk_next = spi_clk_reg;
    spi_data_next = spi_data_reg;
    start_next = start_reg;
    valid_next = valid_reg;
    half_done = div_cnt_reg == SPI_CNT_W'(SPI_HALF - 1);
    cur_fmt = (idx_reg == IDX_RST) ? tlc_fmt_t'(pkt_fmt) : fmt_reg;
    cur_idx = idx_reg;
    extra_slot = cur_fmt != FMT_188 && idx_reg >= 8'(PKT_DATA_LEN);
    dummy_slot = extra_slot && cur_fmt == FMT_204_DUMMY;
    avail = dummy_slot || src_valid;
    load = 1'b0;
    if (spi_state_reg != SPI_IDLE) begin
      div_cnt_next = half_done ? '0 : div_cnt_reg + 1'b1;
    end
    case (spi_state_reg)
      SPI_IDLE: begin
        load = avail;
      end
      SPI_LOW: begin
        if (half_done) begin
          spi_clk_next = 1'b1;
          spi_state_next = SPI_HIGH;
        end
      end
      SPI_HIGH: begin
        if (half_done) begin
          spi_clk_next = 1'b0;
          spi_state_next = SPI_IDLE;
          load = avail;
        end
      end
      default: begin
        spi_state_next = SPI_IDLE;
        spi_clk_next = 1'b0;
      end
    endcase
    if (load) begin
      fmt_next = cur_fmt;
      spi_data_next = dummy_slot ? DUMMY_BYTE : src_data;
      start_next = cur_idx == IDX_RST;
      valid_next = !dummy_slot;
      spi_state_next = SPI_LOW;
      div_cnt_next = '0;
      if (cur_idx == 8'((cur_fmt == FMT_188) ? PKT_DATA_LEN - 1 : PKT_LONG_LEN - 1)) begin
        idx_next = IDX_RST;
      end else begin
        idx_next = cur_idx + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spi_state_reg <= SPI_IDLE;
      fmt_reg <= FMT_188;
      div_cnt_reg <= '0;
      idx_reg <= IDX_RST;
      spi_clk_reg <= 1'b0;
      spi_data_reg <= DUMMY_BYTE;
      start_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else if (ce) begin
      spi_state_reg <= spi_state_next;
      fmt_reg <= fmt_next;
      div_cnt_reg <= div_cnt_next;
      idx_reg <= idx_next;
      spi_clk_reg <= spi_clk_next;
      spi_data_reg <= spi_data_next;
      start_reg <= start_next;
      valid_reg <= valid_next;
    end
  end

  assign src_ready = ce && load && !dummy_slot;
  assign spi_clk = spi_clk_reg;
  assign spi_data = spi_data_reg;
  assign packet_start_flag = start_reg;
  assign byte_valid_flag = valid_reg;

  // ----------------------------------------
  // Serial transmit handshake and receive return, system side
  // ----------------------------------------
  logic xreq_reg, xreq_next;
  logic [8:0] xdata_reg, xdata_next;
  logic ack_s1_reg, ack_s2_reg;
  logic link_ack_reg;
  logic rx_t1_reg, rx_t2_reg, rx_t3_reg;
  logic [7:0] rx_hold_reg;
  logic out_valid_reg, out_valid_next;
  logic [7:0] out_data_reg, out_data_next;
  logic lock_s1_reg, lock_s2_reg;
  logic link_lock_reg;
  logic rx_tgl_reg;

  always_comb begin
    xreq_next = xreq_reg;
    xdata_next = xdata_reg;
    asi_in_ready = ce && (xreq_reg == ack_s2_reg);
    if (asi_in_ready && asi_in_valid) begin
      xreq_next = ~xreq_reg;
      xdata_next = {asi_in_start, asi_in_data};
    end
    out_valid_next = rx_t2_reg != rx_t3_reg;
    out_data_next = out_valid_next ? rx_hold_reg : out_data_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      xreq_reg <= 1'b0;
      xdata_reg <= 9'h000;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      rx_t1_reg <= 1'b0;
      rx_t2_reg <= 1'b0;
      rx_t3_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_data_reg <= DUMMY_BYTE;
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else if (ce) begin
      xreq_reg <= xreq_next;
      xdata_reg <= xdata_next;
      ack_s1_reg <= link_ack_reg;
      ack_s2_reg <= ack_s1_reg;
      rx_t1_reg <= rx_tgl_reg;
      rx_t2_reg <= rx_t1_reg;
      rx_t3_reg <= rx_t2_reg;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      lock_s1_reg <= link_lock_reg;
      lock_s2_reg <= lock_s1_reg;
    end
  end

  assign asi_out_valid = out_valid_reg;
  assign asi_out_data = out_data_reg;
  assign asi_locked = lock_s2_reg;

  // ----------------------------------------
  // Serial link side, word clock domain
  // ----------------------------------------
  logic ce_l1_reg, ce_l2_reg, req_l1_reg, req_l2_reg;
  logic link_ack_next, rd_reg, rd_next;
  logic [1:0] sync_cnt_reg, sync_cnt_next;
  logic [9:0] tx_word_reg, tx_word_next, rx_in_reg;
  logic [19:0] hist_reg, hist_next;
  logic link_lock_next, rx_tgl_next;
  logic [3:0] off_reg, off_next;
  logic [7:0] rx_hold_next;
  logic [10:0] code;
  logic [9:0] win;
  logic [8:0] dword;
  logic comma_hit;

  always_comb begin
    link_ack_next = link_ack_reg;
    rd_next = rd_reg;
    sync_cnt_next = sync_cnt_reg;
    tx_word_next = tx_word_reg;
    hist_next = {hist_reg[9:0], rx_in_reg};
    link_lock_next = link_lock_reg;
    off_next = off_reg;
    rx_tgl_next = rx_tgl_reg;
    rx_hold_next = rx_hold_reg;
    code = 11'h000;
    comma_hit = 1'b0;
    if (req_l2_reg != link_ack_reg && !(xdata_reg[8] && sync_cnt_reg < MIN_SYNC)) begin
      code = enc(xdata_reg[7:0], 1'b0, rd_reg);
      link_ack_next = ~link_ack_reg;
      sync_cnt_next = 2'h0;
    end else begin
      code = enc(DUMMY_BYTE, 1'b1, rd_reg);
      if (sync_cnt_reg < MIN_SYNC) begin
        sync_cnt_next = sync_cnt_reg + 2'h1;
      end
    end
    tx_word_next = code[9:0];
    rd_next = code[10];
    for (int o = 9; o >= 0; o--) begin
      win = hist_next[19 - o -: 10];
      if (win == COMMA_NEG || win == COMMA_POS) begin
        comma_hit = 1'b1;
        off_next = 4'(o);
      end
    end
    win = hist_next[19 - off_reg -: 10];
    dword = dec(win);
    if (comma_hit) begin
      link_lock_next = 1'b1;
    end else if (link_lock_reg && dword[8]) begin
      rx_tgl_next = ~rx_tgl_reg;
      rx_hold_next = dword[7:0];
    end
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      ce_l1_reg <= 1'b0;
      ce_l2_reg <= 1'b0;
      req_l1_reg <= 1'b0;
      req_l2_reg <= 1'b0;
      link_ack_reg <= 1'b0;
      rd_reg <= 1'b0;
      sync_cnt_reg <= 2'h0;
      tx_word_reg <= WORD_RST;
      rx_in_reg <= WORD_RST;
      hist_reg <= 20'h00000;
      link_lock_reg <= 1'b0;
      off_reg <= 4'h0;
      rx_tgl_reg <= 1'b0;
      rx_hold_reg <= DUMMY_BYTE;
    end else begin
      ce_l1_reg <= ce;
      ce_l2_reg <= ce_l1_reg;
      if (ce_l2_reg) begin
        req_l1_reg <= xreq_reg;
        req_l2_reg <= req_l1_reg;
        link_ack_reg <= link_ack_next;
        rd_reg <= rd_next;
        sync_cnt_reg <= sync_cnt_next;
        tx_word_reg <= tx_word_next;
        rx_in_reg <= asi_rx_word;
        hist_reg <= hist_next;
        link_lock_reg <= link_lock_next;
        off_reg <= off_next;
        rx_tgl_reg <= rx_tgl_next;
        rx_hold_reg <= rx_hold_next;
      end
    end
  end

  assign asi_tx_word = tx_word_reg;
endmodule // tlc_host

// [verif/tlc_dev_model.sv]
// Transcoder model: returns every serial word it receives, shifted by slip bits.
// Assumes words arrive one per link_clk, bit 9 first.
`timescale 1ns/10ps
module tlc_dev_model #(
  parameter int ZRUN = 4
) (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic [3:0] slip,
  input wire logic [9:0] tx_word,
  output logic [9:0] rx_word,
  output logic [1:0] line_sym
);
  // ----------------------------------------
  // Loopback with bit slip
  // ----------------------------------------
  logic [19:0] hist_reg;
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      hist_reg <= 20'h00000;
    end else begin
      hist_reg <= {hist_reg[9:0], tx_word};
    end
  end
  assign rx_word = 10'(hist_reg >> (5'h0a - {1'b0, slip}));
  // ----------------------------------------
  // Bipolar line coder, first word bit per word clock
  // ----------------------------------------
  logic [1:0] sym_reg [ZRUN];
  logic pol_reg;
  logic odd_reg;
  logic [2:0] zc_reg;
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < ZRUN; i++) sym_reg[i] <= 2'h0;
      pol_reg <= 1'b0;
      odd_reg <= 1'b0;
      zc_reg <= 3'h0;
    end else begin
      for (int i = 1; i < ZRUN; i++) sym_reg[i] <= sym_reg[i - 1];
      if (tx_word[9]) begin
        sym_reg[0] <= {pol_reg, 1'b1};
        pol_reg <= ~pol_reg;
        odd_reg <= ~odd_reg;
        zc_reg <= 3'h0;
      end else if (32'(zc_reg) == ZRUN - 1) begin
        if (odd_reg) begin
          sym_reg[0] <= {~pol_reg, 1'b1};
        end else begin
          sym_reg[ZRUN - 1] <= {pol_reg, 1'b1};
          sym_reg[0] <= {pol_reg, 1'b1};
          pol_reg <= ~pol_reg;
        end
        odd_reg <= 1'b0;
        zc_reg <= 3'h0;
      end else begin
        sym_reg[0] <= 2'h0;
        zc_reg <= zc_reg + 3'h1;
      end
    end
  end
  assign line_sym = sym_reg[ZRUN - 1];
endmodule // tlc_dev_model

// [verif/tlc_host_monitor.sv]
// Port checker for the line-coding host controller.
// Assumes binding onto tlc_host; everything is checked in the clk domain.
`timescale 1ns/10ps
module tlc_host_monitor
  import tlc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic src_valid,
  input wire logic [7:0] src_data,
  input wire logic src_ready,
  input wire logic spi_clk,
  input wire logic [7:0] spi_data,
  input wire logic packet_start_flag,
  input wire logic byte_valid_flag,
  input wire logic asi_in_valid,
  input wire logic asi_in_ready,
  input wire logic asi_out_valid,
  input wire logic asi_locked
);
  // ----------------------------------------
  // High phase counter and assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [4:0] hi_cnt_reg;
  logic [4:0] hi_cnt_next;
  always_comb begin
    hi_cnt_next = spi_clk ? hi_cnt_reg + 5'h01 : 5'h00;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_reg <= 5'h00;
    end else begin
      hi_cnt_reg <= hi_cnt_next;
    end
  end
  AST_SPI_HIGH_TIME: assert property ($fell(spi_clk) |-> hi_cnt_reg == 5'h0a)
    else $error("spi clock high phase wrong");
  AST_SPI_STABLE: assert property ($rose(spi_clk) |-> $stable(spi_data) && $stable(packet_start_flag))
    else $error("spi data moved at rising clock");
  AST_SPI_LOAD: assert property (src_valid && src_ready |=> spi_data == $past(src_data) && !spi_clk
    ##[9:10] $rose(spi_clk)) else $error("spi byte not loaded");
  AST_SRC_SPACING: assert property (src_valid && src_ready |=> !src_ready [*8])
    else $error("source taken too fast");
  AST_DUMMY: assert property (spi_clk && !byte_valid_flag |-> spi_data == DUMMY_BYTE && !packet_start_flag)
    else $error("dummy slot wrong");
  AST_START_VALID: assert property (packet_start_flag |-> byte_valid_flag)
    else $error("start byte not valid");
  AST_ASI_ACCEPT: assert property (asi_in_valid && asi_in_ready |=> !asi_in_ready)
    else $error("serial byte overrun");
  AST_OUT_LOCKED: assert property (asi_out_valid |-> asi_locked)
    else $error("output before lock");
  AST_OUT_PULSE: assert property (asi_out_valid |=> !asi_out_valid [*4])
    else $error("output pulse too long");
  COV_DUMMY: cover property ($fell(byte_valid_flag));
  COV_START: cover property ($rose(packet_start_flag));
  COV_RX: cover property (asi_out_valid);
endmodule // tlc_host_monitor

bind tlc_host tlc_host_monitor i_mon (
  .clk(clk), .resetn(resetn), .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
  .spi_clk(spi_clk), .spi_data(spi_data), .packet_start_flag(packet_start_flag),
  .byte_valid_flag(byte_valid_flag), .asi_in_valid(asi_in_valid), .asi_in_ready(asi_in_ready),
  .asi_out_valid(asi_out_valid), .asi_locked(asi_locked));

// [verif/tlc_host_test.sv]
// Self-checking bench for the line-coding host controller.
// Assumes the device model loops serial words back with a fixed bit slip.
`timescale 1ns/10ps
module tlc_host_test
  import tlc_pkg::*;
;
  // ----------------------------------------
  // Signals, clocks, checks
  // ----------------------------------------
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [1:0] pkt_fmt = FMT_188;
  logic src_valid = 1'b0;
  logic [7:0] src_data = 8'h00;
  logic asi_in_valid = 1'b0;
  logic asi_in_start = 1'b0;
  logic [7:0] asi_in_data = 8'h00;
  logic [3:0] slip = 4'h3;
  logic src_ready, spi_clk, packet_start_flag, byte_valid_flag, asi_in_ready, asi_out_valid, asi_locked;
  logic [7:0] spi_data, asi_out_data;
  logic [9:0] asi_tx_word, asi_rx_word;
  logic [1:0] line_sym;
  logic line_on = 1'b0;
  int zrun_cnt = 0;
  int rds = 0;
  integer error_cnt = 0;
  integer check_count = 0;
  integer seed = 39531;
  logic [7:0] src_q[$];
  logic [7:0] asi_q[$];
  logic [1:0] cap_fmt = FMT_188;
  int cap_idx = 0;
  int cap_n = 0;
  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #24 link_clk = ~link_clk;
  end
  tlc_host i_dut (
    .clk(clk), .resetn(resetn), .ce(ce), .link_clk(link_clk), .pkt_fmt(pkt_fmt), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready), .spi_clk(spi_clk), .spi_data(spi_data),
    .packet_start_flag(packet_start_flag), .byte_valid_flag(byte_valid_flag), .asi_in_valid(asi_in_valid),
    .asi_in_start(asi_in_start), .asi_in_data(asi_in_data), .asi_in_ready(asi_in_ready),
    .asi_tx_word(asi_tx_word), .asi_rx_word(asi_rx_word), .asi_out_valid(asi_out_valid),
    .asi_out_data(asi_out_data), .asi_locked(asi_locked));
  tlc_dev_model i_dev (.link_clk(link_clk), .resetn(resetn), .slip(slip), .tx_word(asi_tx_word),
    .rx_word(asi_rx_word), .line_sym(line_sym));
  always @(posedge link_clk) line_on <= resetn;
  always @(negedge link_clk) begin
    if (line_on) begin
      zrun_cnt = (line_sym == 2'h0) ? zrun_cnt + 1 : 0;
      rds += (line_sym == 2'h1) ? 1 : ((line_sym == 2'h3) ? -1 : 0);
      chk("zero run", 10'h000, {9'h000, zrun_cnt >= 4});
      chk("line dc", 10'h000, {9'h000, rds > 3 || rds < -3});
    end
  end
  function automatic logic exp_valid(input logic [1:0] f, input int i);
    return !(f == FMT_204_DUMMY && i >= PKT_DATA_LEN);
  endfunction
  function automatic int exp_len(input logic [1:0] f);
    return (f == FMT_188) ? PKT_DATA_LEN : PKT_LONG_LEN;
  endfunction
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Observers
  // ----------------------------------------
  always @(posedge spi_clk) begin
    logic [7:0] eb;
    if (cap_idx == 0) cap_fmt = pkt_fmt;
    eb = DUMMY_BYTE;
    if (exp_valid(cap_fmt, cap_idx) && src_q.size() > 0) eb = src_q.pop_front();
    chk("start", {9'h000, cap_idx == 0}, {9'h000, packet_start_flag});
    chk("valid", {9'h000, exp_valid(cap_fmt, cap_idx)}, {9'h000, byte_valid_flag});
    chk("spi data", {2'b00, eb}, {2'b00, spi_data});
    cap_idx = (cap_idx + 1) % exp_len(cap_fmt);
    cap_n++;
  end
  always @(posedge clk) begin
    if (asi_out_valid === 1'b1) begin
      chk("asi extra", 10'h001, {9'h000, asi_q.size() > 0});
      if (asi_q.size() > 0) chk("asi data", {2'b00, asi_q.pop_front()}, {2'b00, asi_out_data});
    end
  end
  // ----------------------------------------
  // Drivers and tests
  // ----------------------------------------
  task automatic send_src(input logic [7:0] b);
    int n;
    @(negedge clk);
    src_valid = 1'b1;
    src_data = b;
    n = 0;
    @(posedge clk);
    while (src_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk("src take", 10'h001, {9'h000, src_ready});
    if (src_ready === 1'b1) src_q.push_back(b);
  endtask
  task automatic send_asi(input logic [7:0] b, input logic st);
    int n;
    @(negedge clk);
    asi_in_valid = 1'b1;
    asi_in_data = b;
    asi_in_start = st;
    n = 0;
    @(posedge clk);
    while (asi_in_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk("asi take", 10'h001, {9'h000, asi_in_ready});
    if (asi_in_ready === 1'b1) asi_q.push_back(b);
    @(negedge clk);
    asi_in_valid = 1'b0;
  endtask
  task automatic spi_test();
    logic [1:0] fmts [3] = '{FMT_204_DUMMY, FMT_188, FMT_204_VALID};
    int tgt;
    int n;
    tgt = 0;
    for (int p = 0; p < 3; p++) begin
      @(negedge clk);
      pkt_fmt = fmts[p];
      for (int i = 0; i < ((fmts[p] == FMT_204_VALID) ? PKT_LONG_LEN : PKT_DATA_LEN); i++) begin
        send_src(8'($random(seed)));
        if (($random(seed) & 15) == 0) begin
          @(negedge clk);
          src_valid = 1'b0;
          repeat (1 + ($random(seed) & 31)) @(negedge clk);
        end
      end
      @(negedge clk);
      src_valid = 1'b0;
      tgt += exp_len(fmts[p]);
      n = 0;
      while (cap_n < tgt && n < 1000) begin
        @(negedge clk);
        n++;
      end
      chk("spi bytes", 10'(tgt), 10'(cap_n));
    end
    $display("test spi done");
  endtask
  task automatic asi_test();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 20; i++) begin
        send_asi(8'($random(seed)), i == 0);
        if (($random(seed) & 3) == 0) repeat (1 + ($random(seed) & 63)) @(negedge clk);
      end
      repeat (200) @(negedge clk);
    end
    $display("test asi done");
  endtask
  initial begin
    slip = 4'(1 + {$random(seed)} % 9);
    repeat (3) @(posedge link_clk);
    @(negedge clk);
    resetn = 1'b1;
    fork
      spi_test();
      asi_test();
    join
    chk("locked", 10'h001, {9'h000, asi_locked});
    chk("asi left", 10'h000, 10'(asi_q.size()));
    end_of_test();
  end
  initial begin
    #300000;
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    end_of_test();
  end
endmodule // tlc_host_test
